// ===== logic/ppd_pkg.sv
// constants and types for the piezo motor pulse driver
package ppd_pkg;

    // -----------------------------------------------------------------
    // bus addressing
    // -----------------------------------------------------------------
    localparam logic [6:0] BUS_ADDR_LO   = 7'h54;
    localparam logic [6:0] BUS_ADDR_HI   = 7'h55;

    // -----------------------------------------------------------------
    // register numbers
    // -----------------------------------------------------------------
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_PERIOD    = 8'h01;
    localparam logic [7:0] REG_CNT_HI    = 8'h02;
    localparam logic [7:0] REG_CNT_LO    = 8'h03;
    localparam logic [7:0] REG_WIDTH     = 8'h04;
    localparam logic [7:0] REG_SHIFT     = 8'h05;

    // -----------------------------------------------------------------
    // values after reset
    // -----------------------------------------------------------------
    localparam logic [7:0] CTRL_RST      = 8'h03;
    localparam logic [7:0] PERIOD_RST    = 8'h91;
    localparam logic [7:0] CNT_HI_RST    = 8'h00;
    localparam logic [7:0] CNT_LO_RST    = 8'h00;
    localparam logic [7:0] WIDTH_RST     = 8'h00;
    localparam logic [7:0] SHIFT_RST     = 8'h00;

    // -----------------------------------------------------------------
    // field positions
    // -----------------------------------------------------------------
    localparam int         CTRL_P2_BIT   = 0;
    localparam int         CTRL_P1_BIT   = 1;
    localparam int         CTRL_CAL_LSB  = 2;
    localparam int         CNT_DIR_BIT   = 6;
    localparam int         CNT_PMSB_BIT  = 7;

    // -----------------------------------------------------------------
    // timing
    // -----------------------------------------------------------------
    localparam int         CLK_PERIOD_NS = 10;
    localparam int         VCO_UNIT_NS   = 40;
    localparam int         VCO_DIV       = VCO_UNIT_NS / CLK_PERIOD_NS;
    localparam logic [7:0] VCO_DIV_M1    = 8'(VCO_DIV - 1);
    localparam logic [8:0] PER_MIN       = 9'h002;
    localparam logic [7:0] HYB_FULL      = 8'h80;

    // -----------------------------------------------------------------
    // types
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {
        CAL_NONE,
        CAL_INCR,
        CAL_SWEEP,
        CAL_RSVD
    } ppd_cal_e;

    typedef enum logic [2:0] {
        LS_IDLE,
        LS_ADDR,
        LS_REG,
        LS_DATA,
        LS_SKIP
    } ppd_link_e;

endpackage

// ===== logic/ppd_top.sv
// serial register slave and two-phase pulse generator
//
// What this block does
// R1: answer bus address 54h with select pin low, 55h with it high.
// R2: address sits in upper seven bits, bit 0 zero; writes only.
// R3: acknowledge each accepted byte by pulling data low on ninth clock.
// R4: second byte of a transfer selects the first register written.
// R5: later bytes go to the selected register, number rising per byte.
// R6: count upper three bits live in register 02, lower eight in 03.
// R7: with many devices the host uses the select pin as chip select.
// R8: two square drive waveforms, each full bridge or half bridge.
// R9: direction bit picks which phase leads the other.
// R10: width register zero gives high time of half the period.
// R11: shift register zero delays the lagging phase by a quarter period.
// R12: hybrid mode mixes full and half bridge pulses by a ratio.
// R13: non-zero count write starts pulses spaced by the period register.
// R14: count drops per pulse; stops at zero or on a zero write.
// R15: pulse count is eleven bits, at most 2047 pulses.
// R16: host reloads the count before it expires, about every 10 ms.
// R17: period counts internal oscillator cycles of 40 ns each.
// R18: calibration tunes the oscillator and never alters the period.
// R19: host loads period, sweeps once, then calibrates incrementally.
// R20: sweep start is control 6B, period 91, count 77 FF.
// R21: standby pin puts the block into a quiet low-power state.
// R22: calibrate field 00 none, 01 incremental, 10 sweep, 11 reserved.
// R23: bit 6 of the high count byte is the direction.
// R24: zero count or power-down stops at once, all outputs low.
// R25: standby low or reset clears width and shift registers.
// R26: a read request is not acknowledged and changes nothing.
`timescale 1ns/1ns
`default_nettype none

module ppd_top
    import ppd_pkg::*;
(
    // system
    input  wire logic       mclk_i,
    input  wire logic       arst_n_i,
    // serial link
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    input  wire logic       adr_sel_i,
    // mode pins
    input  wire logic       standby_n_pin_i,
    input  wire logic       half_bridge_i,
    input  wire logic       hybrid_en_i,
    input  wire logic [7:0] hybrid_ratio_i,
    // drive outputs
    output logic            ph1_hi_o,
    output logic            ph1_lo_o,
    output logic            ph2_hi_o,
    output logic            ph2_lo_o,
    output logic [1:0]      cal_mode_o
);

    // -----------------------------------------------------------------
    // elaboration check
    // -----------------------------------------------------------------
    if (VCO_DIV < 1 || VCO_DIV > 256 ||
        VCO_UNIT_NS % CLK_PERIOD_NS != 0) begin : g_bad_ratio
        $error("oscillator unit is not a whole number of clocks");
    end

    // -----------------------------------------------------------------
    // reset release
    // -----------------------------------------------------------------
    logic rst_s1_reg;
    logic rst_n_reg;

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_s1_reg <= 1'b0;
            rst_n_reg  <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n_reg  <= rst_s1_reg;
        end
    end

    // -----------------------------------------------------------------
    // start condition detector
    // -----------------------------------------------------------------
    // link clock stands still between frames, so the released main
    // reset also clears the link side; a start toggles this flag
    logic start_tgl_reg;

    always_ff @(negedge sda_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            start_tgl_reg <= 1'b0;
        end else if (scl_i) begin
            start_tgl_reg <= ~start_tgl_reg;
        end
    end

    // -----------------------------------------------------------------
    // link side, clocked by the serial clock
    // -----------------------------------------------------------------
    ppd_link_e  link_reg;
    logic       start_seen_reg;
    logic [3:0] bcnt_reg;
    logic [6:0] shift_in_reg;
    logic [7:0] ptr_reg;
    logic       ack_want_reg;
    logic       ack_reg;
    logic [7:0] wr_addr_reg;
    logic [7:0] wr_data_reg;
    logic       wr_tgl_reg;
    logic       adr_s1_reg;
    logic       adr_s2_reg;
    logic       start_new;
    logic [7:0] byte_in;
    logic [6:0] my_addr;
    logic       byte_done;

    // start hold time keeps the flag settled well before this edge
    assign start_new = start_tgl_reg != start_seen_reg;
    assign byte_in   = {shift_in_reg, sda_i};
    assign my_addr   = adr_s2_reg ? BUS_ADDR_HI : BUS_ADDR_LO;
    assign byte_done = !start_new && bcnt_reg == 4'h7;

    always_ff @(posedge scl_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            adr_s1_reg <= 1'b0;
            adr_s2_reg <= 1'b0;
        end else begin
            adr_s1_reg <= adr_sel_i;
            adr_s2_reg <= adr_s1_reg;
        end
    end

    always_ff @(posedge scl_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            link_reg       <= LS_IDLE;
            start_seen_reg <= 1'b0;
            bcnt_reg       <= 4'h0;
            shift_in_reg   <= 7'h00;
            ptr_reg        <= 8'h00;
            ack_want_reg   <= 1'b0;
        end else if (start_new) begin
            start_seen_reg <= start_tgl_reg;
            shift_in_reg   <= {6'h00, sda_i};
            bcnt_reg       <= 4'h1;
            link_reg       <= LS_ADDR;
            ack_want_reg   <= 1'b0;
        end else if (link_reg != LS_IDLE) begin
            if (bcnt_reg < 4'h7) begin
                shift_in_reg <= {shift_in_reg[5:0], sda_i};
                bcnt_reg     <= bcnt_reg + 4'h1;
            end else if (bcnt_reg == 4'h7) begin
                bcnt_reg <= 4'h8;
                unique case (link_reg)
                    LS_ADDR: begin
                        // read bit set never matches
                        if (byte_in == {my_addr, 1'b0}) begin // R1 R2 R26
                            ack_want_reg <= 1'b1;
                            link_reg     <= LS_REG;
                        end else begin
                            ack_want_reg <= 1'b0;
                            link_reg     <= LS_SKIP;
                        end
                    end
                    LS_REG: begin
                        ptr_reg      <= byte_in; // R4
                        ack_want_reg <= 1'b1;
                        link_reg     <= LS_DATA;
                    end
                    LS_DATA: begin
                        ptr_reg      <= ptr_reg + 8'h01; // R5
                        ack_want_reg <= 1'b1;
                    end
                    default: begin
                        ack_want_reg <= 1'b0;
                    end
                endcase
            end else begin
                bcnt_reg <= 4'h0;
            end
        end
    end

    // word and toggle change together; the far side reads them later
    always_ff @(posedge scl_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            wr_addr_reg <= 8'h00;
            wr_data_reg <= 8'h00;
            wr_tgl_reg  <= 1'b0;
        end else if (byte_done && link_reg == LS_DATA) begin
            wr_addr_reg <= ptr_reg; // R5
            wr_data_reg <= byte_in;
            wr_tgl_reg  <= ~wr_tgl_reg;
        end
    end

    // ack drives in the ninth clock's low phase
    always_ff @(negedge scl_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= bcnt_reg == 4'h8 && ack_want_reg; // R3
        end
    end

    assign sda_o    = 1'b0;
    assign sda_oe_o = ack_reg;

    // -----------------------------------------------------------------
    // crossing into the main clock
    // -----------------------------------------------------------------
    logic        wr_s1_reg;
    logic        wr_s2_reg;
    logic        wr_s3_reg;
    logic        wr_evt;
    logic [10:0] pin_s1_reg;
    logic [10:0] pin_s2_reg;
    logic        stby_n;
    logic        half_br;
    logic        hyb_en;
    logic [7:0]  hyb_ratio;

    always_ff @(posedge mclk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            wr_s1_reg  <= 1'b0;
            wr_s2_reg  <= 1'b0;
            wr_s3_reg  <= 1'b0;
            pin_s1_reg <= 11'h000;
            pin_s2_reg <= 11'h000;
        end else begin
            wr_s1_reg  <= wr_tgl_reg;
            wr_s2_reg  <= wr_s1_reg;
            wr_s3_reg  <= wr_s2_reg;
            pin_s1_reg <= {standby_n_pin_i, half_bridge_i,
                           hybrid_en_i, hybrid_ratio_i};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    assign wr_evt    = wr_s2_reg ^ wr_s3_reg;
    assign stby_n    = pin_s2_reg[10];
    assign half_br   = pin_s2_reg[9];
    assign hyb_en    = pin_s2_reg[8];
    assign hyb_ratio = pin_s2_reg[7:0];

    // -----------------------------------------------------------------
    // register file
    // -----------------------------------------------------------------
    logic [7:0] ctrl_reg;
    logic [7:0] period_reg;
    logic [7:0] cnt_hi_reg;
    logic [7:0] cnt_lo_reg;
    logic [7:0] width_reg;
    logic [7:0] phase_reg;

    // only the bus writes the period; calibration leaves it alone
    always_ff @(posedge mclk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            ctrl_reg   <= CTRL_RST;
            period_reg <= PERIOD_RST;
            cnt_hi_reg <= CNT_HI_RST;
            cnt_lo_reg <= CNT_LO_RST;
        end else if (wr_evt) begin
            case (wr_addr_reg)
                REG_CTRL:   ctrl_reg   <= wr_data_reg;
                REG_PERIOD: period_reg <= wr_data_reg; // R18
                REG_CNT_HI: cnt_hi_reg <= wr_data_reg; // R6
                REG_CNT_LO: cnt_lo_reg <= wr_data_reg; // R6
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            width_reg <= WIDTH_RST;
            phase_reg <= SHIFT_RST;
        end else if (!stby_n) begin
            width_reg <= WIDTH_RST; // R25
            phase_reg <= SHIFT_RST; // R25
        end else if (wr_evt && wr_addr_reg == REG_WIDTH) begin
            width_reg <= wr_data_reg;
        end else if (wr_evt && wr_addr_reg == REG_SHIFT) begin
            phase_reg <= wr_data_reg;
        end
    end

    // reserved code acts as no calibration
    ppd_cal_e cal_code;
    assign cal_code = ppd_cal_e'(ctrl_reg[CTRL_CAL_LSB +: 2]);

    always_ff @(posedge mclk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            cal_mode_o <= CAL_NONE;
        end else begin
            cal_mode_o <= (cal_code == CAL_RSVD) ? CAL_NONE : cal_code; // R22
        end
    end

    // -----------------------------------------------------------------
    // pulse counter and period timer
    // -----------------------------------------------------------------
    logic [10:0] count_reg;
    logic [8:0]  ph_reg;
    logic [7:0]  div_reg;
    logic [8:0]  per;
    logic [10:0] cnt_new;
    logic        cnt_load;
    logic        run;
    logic        tick;
    logic        wrap;

    assign per      = {cnt_hi_reg[CNT_PMSB_BIT], period_reg}; // R17
    assign cnt_load = wr_evt && wr_addr_reg == REG_CNT_LO;
    assign cnt_new  = {cnt_hi_reg[2:0], wr_data_reg}; // R6 R15
    assign run      = count_reg != 11'h000 && stby_n && per >= PER_MIN;
    assign tick     = div_reg == VCO_DIV_M1; // R17
    assign wrap     = tick && ph_reg >= per - 9'h001;

    // divider stands in for the oscillator; restarting it with each
    // load keeps the first pulse of a burst at its full high time
    always_ff @(posedge mclk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            div_reg <= 8'h00;
        end else if (tick || !run || cnt_load) begin // R10 R17
            div_reg <= 8'h00;
        end else begin
            div_reg <= div_reg + 8'h01;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            count_reg <= 11'h000;
        end else if (!stby_n) begin
            count_reg <= 11'h000; // R21 R24
        end else if (cnt_load) begin
            count_reg <= cnt_new; // R13 R14
        end else if (run && wrap) begin
            count_reg <= count_reg - 11'h001; // R14
        end
    end

    // a reload restarts the current pulse from its beginning
    always_ff @(posedge mclk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            ph_reg <= 9'h000;
        end else if (!run || cnt_load) begin
            ph_reg <= 9'h000;
        end else if (tick) begin
            ph_reg <= wrap ? 9'h000 : ph_reg + 9'h001; // R13
        end
    end

    // -----------------------------------------------------------------
    // hybrid bridge mix
    // -----------------------------------------------------------------
    logic [7:0] acc_reg;
    logic       full_reg;
    logic [7:0] ratio;
    logic [8:0] acc_sum;

    assign ratio   = (hyb_ratio > HYB_FULL) ? HYB_FULL : hyb_ratio;
    assign acc_sum = {1'b0, acc_reg} + {1'b0, ratio};

    // error feedback spreads full pulses evenly over the burst
    always_ff @(posedge mclk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            acc_reg  <= 8'h00;
            full_reg <= 1'b0;
        end else if (!run) begin
            acc_reg  <= 8'h00;
            full_reg <= 1'b0;
        end else if (wrap) begin
            if (acc_sum >= {1'b0, HYB_FULL}) begin // R12
                acc_reg  <= 8'(acc_sum - {1'b0, HYB_FULL});
                full_reg <= 1'b1;
            end else begin
                acc_reg  <= acc_sum[7:0];
                full_reg <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------------
    // waveform shaping
    // -----------------------------------------------------------------
    logic [8:0] hi_t;
    logic [8:0] sh;
    logic [9:0] phb;
    logic       wa;
    logic       wb;
    logic       w1;
    logic       w2;
    logic       dir;
    logic       full;

    assign hi_t = (width_reg == 8'h00) ? (per >> 1) : {1'b0, width_reg}; // R10
    assign sh   = (phase_reg == 8'h00) ? (per >> 2) : {1'b0, phase_reg}; // R11
    // shift beyond the period is unsupported and gives a broken wave
    assign phb  = (ph_reg >= sh) ? {1'b0, ph_reg - sh}
                                 : {1'b0, ph_reg} + {1'b0, per} - {1'b0, sh};
    assign wa   = ph_reg < hi_t;
    assign wb   = phb < {1'b0, hi_t};
    assign dir  = cnt_hi_reg[CNT_DIR_BIT]; // R23
    assign w1   = dir ? wa : wb; // R9
    assign w2   = dir ? wb : wa; // R9
    assign full = hyb_en ? full_reg : ~half_br; // R8 R12

    always_ff @(posedge mclk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            ph1_hi_o <= 1'b0;
            ph1_lo_o <= 1'b0;
            ph2_hi_o <= 1'b0;
            ph2_lo_o <= 1'b0;
        end else if (!run) begin
            ph1_hi_o <= 1'b0; // R24
            ph1_lo_o <= 1'b0;
            ph2_hi_o <= 1'b0;
            ph2_lo_o <= 1'b0;
        end else begin
            ph1_hi_o <= ctrl_reg[CTRL_P1_BIT] & w1; // R8
            ph1_lo_o <= ctrl_reg[CTRL_P1_BIT] & full & ~w1;
            ph2_hi_o <= ctrl_reg[CTRL_P2_BIT] & w2;
            ph2_lo_o <= ctrl_reg[CTRL_P2_BIT] & full & ~w2;
        end
    end

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_reg);

    sequence s_zero_write;
        wr_evt && wr_addr_reg == REG_CNT_LO &&
        wr_data_reg == 8'h00 && cnt_hi_reg[2:0] == 3'h0;
    endsequence

    sequence s_outs_low;
        !ph1_hi_o && !ph1_lo_o && !ph2_hi_o && !ph2_lo_o;
    endsequence

    a_stop_on_zero: assert property ( // R14 R24
        s_zero_write |=> count_reg == 11'h000 ##1 s_outs_low)
        else $error("zero count did not stop the drive");

    a_count_load: assert property ( // R13 R15
        cnt_load && stby_n |=> count_reg == $past(cnt_new))
        else $error("count not loaded from both bytes");

    a_count_step: assert property ( // R14
        run && wrap && !cnt_load |=> count_reg == $past(count_reg) - 11'h001)
        else $error("count not reduced by one per pulse");

    a_period_wrap: assert property ( // R13
        run && wrap && !cnt_load && count_reg != 11'h001
        |=> ph_reg == 9'h000 ##1 ph_reg == 9'h000)
        else $error("period timer did not restart");

    a_standby_clear: assert property ( // R21 R25
        !stby_n |=> width_reg == 8'h00 && phase_reg == 8'h00
                    && count_reg == 11'h000 ##1 s_outs_low)
        else $error("standby did not clear the drive");

    a_half_width: assert property ( // R10
        run && width_reg == 8'h00 && dir && ctrl_reg[CTRL_P1_BIT]
        |=> ph1_hi_o == ($past(ph_reg) < ($past(per) >> 1)))
        else $error("default width is not half period");

    a_quarter_lag: assert property ( // R11 R9
        run && width_reg == 8'h00 && phase_reg == 8'h00 && dir &&
        ctrl_reg[CTRL_P2_BIT] && ph_reg == 9'h000 && per[1:0] == 2'b00
        |=> !ph2_hi_o)
        else $error("second phase not a quarter behind");

    a_read_refused: assert property ( // R26 R2
        @(posedge scl_i) disable iff (!rst_n_reg)
        link_reg == LS_ADDR && byte_done && sda_i
        |=> link_reg == LS_SKIP && !ack_want_reg)
        else $error("read request was accepted");

    a_addr_accept: assert property ( // R1 R3
        @(posedge scl_i) disable iff (!rst_n_reg)
        link_reg == LS_ADDR && byte_done && byte_in == {my_addr, 1'b0}
        |=> link_reg == LS_REG && ack_want_reg && bcnt_reg == 4'h8)
        else $error("own address not acknowledged");

    a_ptr_step: assert property ( // R5
        @(posedge scl_i) disable iff (!rst_n_reg)
        link_reg == LS_DATA && byte_done
        |=> ptr_reg == $past(ptr_reg) + 8'h01)
        else $error("register number did not advance");

endmodule

`default_nettype wire

// ===== verif/ppd_host_model.sv
// serial host model driving the link pins of the pulse driver
`timescale 1ns/1ns
`default_nettype none

module ppd_host_model (
    // link pins, data released means high through the pull-up
    output logic     scl_o,
    output logic     sda_o,
    input  wire logic sda_w_i
);
    logic ack_bit;
    event done_ev;

    // clock stands still high between frames
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    task automatic start_c();
        sda_o = 1'b1;
        #80 sda_o = 1'b0;
        #80 scl_o = 1'b0;
    endtask

    // eight bits msb first, ninth clock with data released
    task automatic send(input logic [7:0] b);
        for (int i = 7; i >= -1; i--) begin
            #40 sda_o = (i < 0) ? 1'b1 : b[i];
            #40 scl_o = 1'b1;
            if (i < 0) ack_bit = sda_w_i;
            #80 scl_o = 1'b0;
        end
        -> done_ev;
    endtask

    task automatic stop_c();
        #40 sda_o = 1'b0;
        #40 scl_o = 1'b1;
        #80 sda_o = 1'b1;
    endtask
endmodule

`default_nettype wire

// ===== verif/tb.sv
// self-checking bench for the pulse driver
`timescale 1ns/1ns
`default_nettype none

module tb;
    import ppd_pkg::*;
    logic        mclk_i    = 1'b0;
    logic        arst_n_i  = 1'b0;
    logic        adr_sel   = 1'b0;
    logic        stby_n    = 1'b1;
    logic [7:0]  ratio     = 8'h00;
    logic        hb = 1'b0, hy = 1'b0, lo = 1'b0;
    logic [31:0] s         = 32'hAEB9;
    logic [7:0]  n;
    logic        p1q, p2q;
    int          bad_count = 0;
    int          checked   = 0;
    int          cyc, rises, t1, hi, lag, idle;
    logic [31:0] bq[$];
    logic        aq[$];
    wire         scl, sda_h, sda_o, sda_oe, ph1h, ph1l, ph2h, ph2l;
    wire [1:0]   cal;
    wire         sda_w = sda_h & ~(sda_oe & ~sda_o);

    ppd_top ppd_top_inst (
        .mclk_i(mclk_i), .arst_n_i(arst_n_i), .scl_i(scl),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe),
        .adr_sel_i(adr_sel), .standby_n_pin_i(stby_n),
        .half_bridge_i(hb), .hybrid_en_i(hy),
        .hybrid_ratio_i(ratio), .ph1_hi_o(ph1h), .ph1_lo_o(ph1l),
        .ph2_hi_o(ph2h), .ph2_lo_o(ph2l), .cal_mode_o(cal));
    ppd_host_model host_inst (.scl_o(scl), .sda_o(sda_h), .sda_w_i(sda_w));

    always #5 mclk_i = ~mclk_i;

    task automatic chk(string nm, logic [31:0] e, logic [31:0] v);
        checked++;
        if (e !== v) begin
            bad_count++;
            $display("mismatch %s exp %h got %h", nm, e, v);
        end
    endtask
    task automatic cmp_ack(logic e, logic v); chk("ack", e, v); endtask
    task automatic cmp_lvl(logic [31:0] e, v); chk("level", e, v); endtask
    task automatic cmp_burst(logic [31:0] e, v);
        chk("burst", e, (e[31:16] == 16'hFFFF) ? {16'hFFFF, v[15:0]} : v);
    endtask

    task automatic wrap_up();
        if (bad_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    function automatic logic [31:0] xs();
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    task automatic tick();
        @(posedge mclk_i);
        #1;
    endtask

    // bytes sit in the low k bytes of w, first byte highest
    task automatic frame(int k, logic [39:0] w, logic ok);
        tick();
        host_inst.start_c();
        for (int i = k - 1; i >= 0; i--) begin
            aq.push_back(!ok);
            host_inst.send(w[i*8 +: 8]);
        end
        host_inst.stop_c();
    endtask

    // bounded wait until every noted burst has been judged
    task automatic settle();
        for (int i = 0; i < 3000 && bq.size() > 0; i++) @(negedge mclk_i);
        if (bq.size() > 0) begin
            bad_count++;
            wrap_up();
        end
    endtask

    task automatic burst(logic [15:0] c, logic [7:0] h, l, logic [39:0] w);
        bq.push_back({c, h, l});
        frame(4, w, 1'b1);
    endtask

    always @(host_inst.done_ev)
        cmp_ack(aq.size() ? aq.pop_front() : 1'bx, host_inst.ack_bit);

    // pulse count, first high time and phase lag, in mclk cycles
    always @(negedge mclk_i) begin
        cyc++;
        if (ph1h === 1'b1 && !p1q) begin
            rises++;
            if (rises == 1) t1 = cyc;
        end
        if (ph1h !== 1'b1 && p1q && rises == 1 && hi == 0) hi = cyc - t1;
        if (ph2h === 1'b1 && !p2q && rises > 0 && lag == 0) lag = cyc - t1;
        idle = (ph1h === 1'b1 || ph2h === 1'b1) ? 0 : idle + 1;
        if (ph1l === 1'b1 || ph2l === 1'b1) lo = 1'b1;
        if (rises > 0 && idle == 100) begin
            cmp_burst(bq.size() ? bq.pop_front() : '1,
                      {16'(rises), 8'(hi), 8'(lag)});
            rises = 0;
            hi = 0;
            lag = 0;
        end
        p1q = (ph1h === 1'b1);
        p2q = (ph2h === 1'b1);
    end

    initial begin
        repeat (20) @(posedge mclk_i);
        #1 arst_n_i = 1'b1;
        repeat (5) tick();
        frame(3, {8'hA8, REG_PERIOD, 8'h91}, 1'b1);
        for (int c = 2; c < 6; c++) begin
            frame(3, {8'hA8, REG_CTRL, 8'h63 | 8'((c % 4) << 2)}, 1'b1);
            cmp_lvl(32'(c % 4 % 3), 32'(cal));
        end
        frame(3, {8'hA9, REG_CTRL, 8'h6B}, 1'b0);
        cmp_lvl(1, 32'(cal));
        frame(3, {8'hAA, REG_CTRL, 8'h6B}, 1'b0);
        cmp_lvl(1, 32'(cal));
        adr_sel = 1'b1;
        frame(3, {8'hAA, REG_CTRL, 8'h6B}, 1'b1);
        frame(3, {8'hA8, REG_CTRL, 8'h63}, 1'b0);
        cmp_lvl(2, 32'(cal));
        adr_sel = 1'b0;
        frame(3, {8'hA8, REG_CTRL, 8'h63}, 1'b1);
        n = 8'(xs() % 6 + 2);
        ratio = 8'(xs());
        bq.push_back({16'(n), 8'd16, 8'd8});
        frame(5, {8'hA8, REG_PERIOD, 8'h08, 8'h40, n}, 1'b1);
        settle();
        frame(3, {8'hAA, REG_CNT_HI, 8'h47}, 1'b0);
        n = 8'(xs() % 6 + 2);
        bq.push_back({16'(n), 8'd16, 8'd8});
        frame(3, {8'hA8, REG_CNT_LO, n}, 1'b1);
        settle();
        cmp_lvl(1, 32'(lo));
        {hb, lo} = 2'b10;
        burst(16'(n), 16, 8, {8'hA8, REG_CNT_HI, 8'h40, n});
        settle();
        cmp_lvl(0, 32'(lo));
        {hy, lo, ratio} = {3'b101, 7'(xs())};
        burst(16'(n), 16, 8, {8'hA8, REG_CNT_HI, 8'h40, n});
        settle();
        cmp_lvl(1, 32'(lo));
        {lo, ratio} = 9'h000;
        burst(16'(n), 16, 8, {8'hA8, REG_CNT_HI, 8'h40, n});
        settle();
        cmp_lvl(0, 32'(lo));
        {hb, hy} = 2'b00;
        burst(16'(n), 16, 24, {8'hA8, REG_CNT_HI, 8'h00, n});
        settle();
        frame(4, {8'hA8, REG_WIDTH, 8'h02, 8'h01}, 1'b1);
        burst(16'(n), 8, 4, {8'hA8, REG_CNT_HI, 8'h40, n});
        settle();
        burst(16'hFFFF, 8, 4, {8'hA8, REG_CNT_HI, 8'h47, 8'hFF});
        repeat (200) tick();
        stby_n = 1'b0;
        repeat (10) tick();
        cmp_lvl(0, 32'({ph1h, ph1l, ph2h, ph2l}));
        stby_n = 1'b1;
        settle();
        burst(16'(n), 16, 8, {8'hA8, REG_CNT_HI, 8'h40, n});
        settle();
        burst(16'hFFFF, 16, 8, {8'hA8, REG_CNT_HI, 8'h47, 8'hFF});
        repeat (200) tick();
        frame(4, {8'hA8, REG_CNT_HI, 8'h47, 8'hFF}, 1'b1);
        frame(4, {8'hA8, REG_CNT_HI, 8'h00, 8'h00}, 1'b1);
        cmp_lvl(0, 32'({ph1h, ph1l, ph2h, ph2l}));
        settle();
        wrap_up();
    end
endmodule

`default_nettype wire
